// ### hw/csd_channel.sv
`timescale 1ns/1ps
module csd_channel
  import csd_pkg::*;
(
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Timing and config
  input  wire logic                 tick,
  input  wire csd_pkg::csd_cfg_t    cfg,
  // Source level and target drive
  input  wire logic                 src_on,
  output logic                      tgt_on,
  output logic                      confirmed
);
  import csd_pkg::*;

  logic             conf_r, conf_nxt;
  logic [DLY_W-1:0] cnt_r,  cnt_nxt;
  logic             tgt_r,  tgt_nxt;

  // Delay confirm of source level
  always_comb begin
    conf_nxt = conf_r;
    cnt_nxt  = cnt_r;
    if (src_on == conf_r) begin
      cnt_nxt = DLY_RESET;
    end else if ((src_on ? cfg.rise_delay : cfg.fall_delay) == DLY_RESET) begin
      conf_nxt = src_on;
    end else if (tick) begin
      if (cnt_r + 14'h0001 >= (src_on ? cfg.rise_delay : cfg.fall_delay)) begin
        conf_nxt = src_on;
        cnt_nxt  = DLY_RESET;
      end else begin
        cnt_nxt = cnt_r + 14'h0001;
      end
    end
    tgt_nxt = (cfg.invert_sel == INV_ON) ? ~conf_nxt : conf_nxt;
  end

  // Registers, cleared to source OFF
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conf_r <= 1'b0;
      cnt_r  <= DLY_RESET;
      tgt_r  <= 1'b0;
    end else begin
      conf_r <= conf_nxt;
      cnt_r  <= cnt_nxt;
      tgt_r  <= tgt_nxt;
    end
  end

  assign tgt_on    = tgt_r;
  assign confirmed = conf_r;
endmodule

// ### hw/csd_pkg.sv
package csd_pkg;
  // Channel count and selector widths
  localparam int          NUM_CH      = 6;
  localparam int          SEL_W       = 8;
  localparam int          NUM_SRC     = 64;
  localparam int          NUM_TGT     = 64;
  localparam logic [7:0]  SEL_NONE    = 8'h00;
  // Inversion codes
  localparam logic [1:0]  INV_OFF     = 2'h0;
  localparam logic [1:0]  INV_ON      = 2'h1;
  // Delay in 10 ms ticks, 0.00 to 100.00 s
  localparam int          DLY_W       = 14;
  localparam logic [13:0] DLY_MAX     = 14'h2710;
  localparam logic [13:0] DLY_RESET   = 14'h0000;
  // Tick timing
  localparam int          CLK_HZ      = 250_000_000;
  localparam int          TICK_MS     = 10;
  localparam int          TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  // Register map, one word per field per channel
  localparam logic [11:0] OFF_TGT     = 12'h000;
  localparam logic [11:0] OFF_SRC     = 12'h040;
  localparam logic [11:0] OFF_INV     = 12'h080;
  localparam logic [11:0] OFF_RISE    = 12'h0c0;
  localparam logic [11:0] OFF_FALL    = 12'h100;
  localparam logic [11:0] OFF_STAT    = 12'h140;
  localparam int          ADDR_W      = 12;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Per-channel configuration
  typedef struct packed {
    logic [SEL_W-1:0] target_sel;
    logic [SEL_W-1:0] source_sel;
    logic [1:0]       invert_sel;
    logic [DLY_W-1:0] rise_delay;
    logic [DLY_W-1:0] fall_delay;
  } csd_cfg_t;
endpackage

// ### hw/csd_top.sv
`timescale 1ns/1ps
// What this block does
// - Six channels, inversion resets to non-inverting.
// - Code 00 copies source level to target.
// - Code 01 drives target opposite to source.
// - Each channel holds its own delays.
// - Rising source waits on-delay before applying.
// - Falling source waits off-delay before applying.
// - On-delay 0 to 100 s, resets zero.
// - Off-delay same range, resets zero.
// - Selectors choose source output, target input.
// - Duplicate selection clears earlier channel's selector.
module csd_top
  import csd_pkg::*;
#(
  parameter int TICK_CYCLES = csd_pkg::TICK_CYC
)(
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address
  input  wire logic [csd_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [csd_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Internal output-terminal functions, same clock
  input  wire logic [csd_pkg::NUM_SRC-1:0] src_func,
  // Internal input-terminal functions driven
  output logic [csd_pkg::NUM_TGT-1:0]      tgt_func,
  output logic [csd_pkg::NUM_TGT-1:0]      tgt_func_valid
);
  import csd_pkg::*;

  // Decode a byte address to field and channel
  function automatic logic [3:0] fld_of(input logic [ADDR_W-1:0] a);
    fld_of = {1'b0, a[8:6]};
  endfunction
  function automatic logic [2:0] ch_of(input logic [ADDR_W-1:0] a);
    ch_of = a[4:2];
  endfunction
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a[5] == 1'b0) && (a[4:2] < 3'h6)
            && (a[ADDR_W-1:9] == 3'h0) && (a[8:6] <= 3'h5);
  endfunction

  csd_cfg_t         cfg_r   [NUM_CH];
  csd_cfg_t         cfg_nxt [NUM_CH];
  logic             ch_tgt  [NUM_CH];
  logic             ch_conf [NUM_CH];
  logic             ch_src  [NUM_CH];

  logic [31:0]      tick_cnt_r, tick_cnt_nxt;
  logic             tick_r,     tick_nxt;

  logic             aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]      wdata_r,   wdata_nxt;
  logic             bvalid_r,  bvalid_nxt;
  logic [1:0]       bresp_r,   bresp_nxt;
  logic             rvalid_r,  rvalid_nxt;
  logic [1:0]       rresp_r,   rresp_nxt;
  logic [31:0]      rdata_r,   rdata_nxt;
  logic [NUM_TGT-1:0] tgt_r, tgt_nxt, tv_r, tv_nxt;
  logic             awready_r, wready_r, arready_r;

  // 10 ms tick generator
  always_comb begin
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 32'h1;
    if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = 32'h0;
      tick_nxt     = 1'b1;
    end
  end

  // Write channel capture and register update
  always_comb begin
    logic [31:0] d;
    logic [SEL_W-1:0] s;
    d           = wdata_r;
    s           = d[SEL_W-1:0];
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    for (int i = 0; i < NUM_CH; i++) cfg_nxt[i] = cfg_r[i];
    if (s_axi_awvalid && !aw_have_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    if (aw_have_r && w_have_r && !bvalid_r) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_SLVERR;
      if (addr_ok(awaddr_r) && fld_of(awaddr_r) != 4'h5) begin
        bresp_nxt = RESP_OKAY;
        case (fld_of(awaddr_r))
          4'h0: begin
            cfg_nxt[ch_of(awaddr_r)].target_sel = s;
            for (int i = 0; i < NUM_CH; i++) begin
              if (i != ch_of(awaddr_r) && s != SEL_NONE && cfg_r[i].target_sel == s)
                cfg_nxt[i].target_sel = SEL_NONE;
            end
          end
          4'h1: begin
            cfg_nxt[ch_of(awaddr_r)].source_sel = s;
            for (int i = 0; i < NUM_CH; i++) begin
              if (i != ch_of(awaddr_r) && s != SEL_NONE && cfg_r[i].source_sel == s)
                cfg_nxt[i].source_sel = SEL_NONE;
            end
          end
          4'h2: cfg_nxt[ch_of(awaddr_r)].invert_sel = d[1] ? INV_OFF : d[1:0];
          4'h3: cfg_nxt[ch_of(awaddr_r)].rise_delay =
                  (d[DLY_W-1:0] > DLY_MAX || d[31:DLY_W] != '0) ? DLY_MAX : d[DLY_W-1:0];
          4'h4: cfg_nxt[ch_of(awaddr_r)].fall_delay =
                  (d[DLY_W-1:0] > DLY_MAX || d[31:DLY_W] != '0) ? DLY_MAX : d[DLY_W-1:0];
          default: bresp_nxt = RESP_SLVERR;
        endcase
      end
    end
  end

  // Read channel
  always_comb begin
    logic [2:0] c;
    c          = ch_of(s_axi_araddr);
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_SLVERR;
      rdata_nxt  = 32'h0;
      if (addr_ok(s_axi_araddr)) begin
        rresp_nxt = RESP_OKAY;
        case (fld_of(s_axi_araddr))
          4'h0: rdata_nxt = {24'h0, cfg_r[c].target_sel};
          4'h1: rdata_nxt = {24'h0, cfg_r[c].source_sel};
          4'h2: rdata_nxt = {30'h0, cfg_r[c].invert_sel};
          4'h3: rdata_nxt = {18'h0, cfg_r[c].rise_delay};
          4'h4: rdata_nxt = {18'h0, cfg_r[c].fall_delay};
          4'h5: rdata_nxt = {30'h0, ch_tgt[c], ch_conf[c]};
          default: rresp_nxt = RESP_SLVERR;
        endcase
      end
    end
  end

  // Channel instances, source routed by selector
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign ch_src[g] = (cfg_r[g].source_sel != SEL_NONE) &&
                       src_func[cfg_r[g].source_sel[5:0]];
    csd_channel u_ch (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .tick      (tick_r),
      .cfg       (cfg_r[g]),
      .src_on    (ch_src[g]),
      .tgt_on    (ch_tgt[g]),
      .confirmed (ch_conf[g])
    );
  end

  // Target routing
  always_comb begin
    tgt_nxt = '0;
    tv_nxt  = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (cfg_r[i].target_sel != SEL_NONE) begin
        tgt_nxt[cfg_r[i].target_sel[5:0]] = ch_tgt[i];
        tv_nxt[cfg_r[i].target_sel[5:0]]  = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_r[i] <= '{SEL_NONE, SEL_NONE, INV_OFF, DLY_RESET, DLY_RESET};
      end
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
      aw_have_r  <= 1'b0;
      w_have_r   <= 1'b0;
      awaddr_r   <= '0;
      wdata_r    <= 32'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      rresp_r    <= RESP_OKAY;
      rdata_r    <= 32'h0;
      tgt_r      <= '0;
      tv_r       <= '0;
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      arready_r  <= 1'b1;
    end else begin
      for (int i = 0; i < NUM_CH; i++) cfg_r[i] <= cfg_nxt[i];
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
      aw_have_r  <= aw_have_nxt;
      w_have_r   <= w_have_nxt;
      awaddr_r   <= awaddr_nxt;
      wdata_r    <= wdata_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rresp_r    <= rresp_nxt;
      rdata_r    <= rdata_nxt;
      tgt_r      <= tgt_nxt;
      tv_r       <= tv_nxt;
      awready_r  <= !aw_have_nxt;                           // Ready mirrors free slot
      wready_r   <= !w_have_nxt;
      arready_r  <= !rvalid_nxt;
    end
  end

  // Outputs from flip-flops
  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rresp    = rresp_r;
  assign s_axi_rdata    = rdata_r;
  assign tgt_func       = tgt_r;
  assign tgt_func_valid = tv_r;
endmodule

// ### test/csd_top_props.sv
`timescale 1ns/1ps
module csd_top_props
  import csd_pkg::*;
#(
  parameter int TICK_CYCLES = 10
)(
  // Clock, reset and handshakes
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  // Bus payloads
  input wire logic [csd_pkg::ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr,
  input wire logic [31:0]                 s_axi_wdata, s_axi_rdata,
  input wire logic [3:0]                  s_axi_wstrb,
  input wire logic [1:0]                  s_axi_bresp, s_axi_rresp,
  // Function levels
  input wire logic [csd_pkg::NUM_SRC-1:0] src_func,
  input wire logic [csd_pkg::NUM_TGT-1:0] tgt_func, tgt_func_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers and holds
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_status_ro: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == OFF_STAT |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
    else $error("status write accepted");
  a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h154
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn
    |=> !s_axi_bvalid && !s_axi_rvalid && tgt_func == '0 && tgt_func_valid == '0)
    else $error("outputs not idle in reset");
  // Main scenarios
  c_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
  c_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
  c_target: cover property ($rose(|tgt_func));
endmodule
bind csd_top csd_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_csd_top_props (.*);

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import csd_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [63:0] src_func, tgt_func, tgt_func_valid;
  logic [33:0] rq[$], bq[$];
  logic [5:0]  t, s;
  int          fail_count, cmp_count, cyc;
  csd_top #(.TICK_CYCLES(10)) u_csd_top (.*);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write with expected response noted
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, dd, done;
    ad = 0;
    dd = 0;
    done = 0;
    @(posedge aclk);
    bq.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($urandom % 2);
    while (!done) begin
      @(posedge aclk);
      done = ad && dd && s_axi_bvalid === 1'b1 && s_axi_bready;
      ad = ad | (s_axi_awready === 1'b1);
      dd = dd | (s_axi_wready === 1'b1);
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !dd;
      s_axi_bready <= !done && (s_axi_bready || 1'($urandom % 2));
    end
  endtask
  // Read with expected word noted
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, done;
    ad = 0;
    done = 0;
    @(posedge aclk);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom % 2);
    while (!done) begin
      @(posedge aclk);
      done = ad && s_axi_rvalid === 1'b1 && s_axi_rready;
      ad = ad | (s_axi_arready === 1'b1);
      s_axi_arvalid <= !ad;
      s_axi_rready <= !done && (s_axi_rready || 1'($urandom % 2));
    end
  endtask
  task automatic cfg(input int c, input logic [5:0] tg, sr, input logic [1:0] inv,
                     input logic [13:0] rs, fl);
    wr(OFF_TGT + 12'(c * 4), {26'h0, tg}, RESP_OKAY);
    wr(OFF_SRC + 12'(c * 4), {26'h0, sr}, RESP_OKAY);
    wr(OFF_INV + 12'(c * 4), {30'h0, inv}, RESP_OKAY);
    wr(OFF_RISE + 12'(c * 4), {18'h0, rs}, RESP_OKAY);
    wr(OFF_FALL + 12'(c * 4), {18'h0, fl}, RESP_OKAY);
  endtask
  // Response monitor against oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk("write", {s_axi_bresp, 32'h0}, bq.pop_front());
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src_func} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(94));
    w(12);
    aresetn <= 1'b1;
    // Reset value of every field except status
    for (int c = 0; c < 6; c++)
      for (int f = 0; f < 5; f++) rd(12'(f * 64 + c * 4), 32'h0, RESP_OKAY);
    $display("reset test done");
    // Both inversion codes, zero delay
    for (int i = 0; i < 2; i++) begin
      t = 6'($urandom_range(63, 1));
      s = 6'($urandom_range(63, 1));
      cfg(i, t, s, 2'(i), 14'h0, 14'h0);
      for (int l = 0; l < 2; l++) begin
        src_func[s] <= 1'(l);
        w(4);
        chk("target", 34'(tgt_func[t]), 34'(l ^ i));
        chk("valid", 34'(tgt_func_valid[t]), 34'h1);
      end
      src_func[s] <= 1'b0;
    end
    $display("inversion test done");
    // Rise 3 ticks, fall 2 ticks, then a cancelled pulse
    t = 6'h0a;
    s = 6'h14;
    cfg(2, t, s, INV_OFF, 14'h3, 14'h2);
    src_func[s] <= 1'b1;
    w(18);
    chk("rise early", 34'(tgt_func[t]), 34'h0);
    w(16);
    chk("rise late", 34'(tgt_func[t]), 34'h1);
    src_func[s] <= 1'b0;
    w(10);
    chk("fall early", 34'(tgt_func[t]), 34'h1);
    w(14);
    chk("fall late", 34'(tgt_func[t]), 34'h0);
    src_func[s] <= 1'b1;
    w(20);
    src_func[s] <= 1'b0;
    w(4);
    src_func[s] <= 1'b1;
    w(18);
    chk("cancel", 34'(tgt_func[t]), 34'h0);
    w(14);
    chk("rerise", 34'(tgt_func[t]), 34'h1);
    rd(OFF_STAT + 12'h8, 32'h3, RESP_OKAY);
    rd(OFF_RISE + 12'h8, 32'h3, RESP_OKAY);
    $display("delay test done");
    // Clamp, duplicate target, errors
    for (int f = 3; f < 5; f++) begin
      wr(12'(f * 64 + 12), 32'h3fff, RESP_OKAY);
      rd(12'(f * 64 + 12), 32'h2710, RESP_OKAY);
    end
    wr(OFF_TGT + 12'hc, 32'ha, RESP_OKAY);
    rd(OFF_TGT + 12'h8, 32'h0, RESP_OKAY);
    rd(OFF_TGT + 12'hc, 32'ha, RESP_OKAY);
    wr(OFF_INV + 12'h10, 32'h2, RESP_OKAY);
    rd(OFF_INV + 12'h10, 32'h0, RESP_OKAY);
    rd(12'hffc, 32'h0, RESP_SLVERR);
    wr(OFF_STAT, 32'h1, RESP_SLVERR);
    // Second reset clears settings
    aresetn <= 1'b0;
    w(3);
    aresetn <= 1'b1;
    rd(OFF_INV + 12'h4, 32'h0, RESP_OKAY);
    $display("error and reset test done");
    w(5);
    final_report();
  end
endmodule
